// ==== rtl/dahg_host_glue.sv ====
// Host side glue: starts conversions, reads result pairs, buffers them.
//
// Overview of operation
// - Start comes from host or external timer.
// - Two back-to-back reads, same address.
// - Read strobe built from strobe and direction.
// - One wait state stretches each read.
// - Address strobe with direction forms read.
// - Decoded address write starts a conversion.
// - Start decode gated by write, distinct address.
// - Avoid reads while conversion is running.
// - Fixed delay may replace busy interrupt.
// - Read strobe also drives transfer acknowledge.
// - One shared read strobe feeds all converters.
// - Each converter gets its own select.
// - Reads end 400 ns before next start.
`timescale 1ns/1ps
`default_nettype none
module dahg_host_glue (
  input  wire logic                            clock_i,
  input  wire logic                            reset_i,
  input  wire logic                            ext_timer_mode_i,
  input  wire logic                            ext_start_n_i,
  input  wire logic                            host_write_i,
  input  wire logic                            start_addr_hit_i,
  input  wire logic                            use_fixed_delay_i,
  input  wire logic [dahg_pkg::SEL_W-1:0]      conv_sel_i,
  input  wire logic [dahg_pkg::NUM_CONV-1:0]   busy_i,
  input  wire logic [dahg_pkg::DATA_W-1:0]     conv_data_i,
  output logic                                 conversion_start_n_o,
  output logic                                 read_n_o,
  output logic      [dahg_pkg::NUM_CONV-1:0]   chip_sel_n_o,
  output logic                                 host_transfer_ack_n_o,
  output logic                                 host_cycle_complete_o,
  output logic                                 done_event_o,
  output logic                                 result_valid_o,
  input  wire logic                            result_ready_i,
  output logic      [dahg_pkg::DATA_W-1:0]     result_data_o,
  output logic                                 result_second_o,
  output logic                                 start_ready_o
);
  import dahg_pkg::*;

  // A read pair starts only when the FIFO has room for both words.
  // A pair therefore never straddles a stall.
  localparam int unsigned       FILL_W     = $clog2(FIFO_DEPTH) + 1;
  localparam logic [FILL_W-1:0] FILL_LIMIT = FILL_W'(FIFO_DEPTH) - FILL_W'(RESULTS_PER_CONV);

  typedef struct packed {
    dahg_state_e        state;
    logic [NUM_CONV-1:0] busy_q;
    logic               done_pend;
    logic [1:0]         rd_cnt;
    logic [CNT_W-1:0]   cnt;
    logic               read_n;
    logic [NUM_CONV-1:0] cs_n;
    logic               ack_n;
    logic               cyc_cpl;
    logic               done_ev;
    logic               push;
    logic [DATA_W-1:0]  word;
    logic               second;
    logic [SEL_W-1:0]   sel;
    logic               start_rdy;
    logic [FILL_W-1:0]  fill;
    logic               out_valid;
    logic [DATA_W-1:0]  out_word;
    logic               out_second;
  } dahg_glue_s;

  dahg_glue_s        st_ff;
  dahg_glue_s        nxt_st;
  dahg_stream_if     strm ();
  logic              start_n;
  logic              start_ev;
  logic              hold_off;
  logic              busy_fall;
  logic [DATA_W:0]   fifo_out;
  logic              fifo_valid;
  logic              fifo_take;
  logic              start_req;
  logic [NUM_CONV-1:0] busy_fall_each;

  // a start is blocked while reading or settling.
  assign hold_off = (st_ff.state != DAHG_IDLE);

  // Same request decode as the start generator.
  // Ready drops in the cycle in which a start is taken, not one cycle later.
  assign start_req = ext_timer_mode_i ? ~ext_start_n_i : (host_write_i & start_addr_hit_i);

  dahg_start_gen u_start (
    .clock_i          (clock_i),
    .reset_i          (reset_i),
    .ext_timer_mode_i (ext_timer_mode_i),
    .ext_start_n_i    (ext_start_n_i),
    .host_write_i     (host_write_i),
    .start_addr_hit_i (start_addr_hit_i),
    .hold_off_i       (hold_off),
    .start_n_o        (start_n),
    .start_event_o    (start_ev)
  );

  // busy falling edge is the completion interrupt.
  for (genvar k = 0; k < NUM_CONV; k++) begin : g_busy
    assign busy_fall_each[k] = st_ff.busy_q[k] & ~busy_i[k];
  end
  assign busy_fall = busy_fall_each[st_ff.sel];

  assign strm.valid = st_ff.push;
  assign strm.data  = st_ff.word;
  assign strm.tag   = st_ff.second;

  dahg_fifo #(
    .WIDTH (DATA_W + 1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .reset_i     (reset_i),
    .in_valid_i  (strm.valid),
    .in_ready_o  (strm.ready),
    .in_data_i   ({strm.tag, strm.data}),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_take),
    .out_data_o  (fifo_out)
  );

  // The output stage refills whenever it is empty or being emptied.
  // This keeps one word per cycle while every output comes from a register.
  assign fifo_take = fifo_valid & (~st_ff.out_valid | result_ready_i);

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.busy_q  = busy_i;
    nxt_st.done_ev = 1'b0;
    nxt_st.push    = 1'b0;
    // The fill count covers words in the FIFO itself, not in the output stage.
    nxt_st.fill    = st_ff.fill + FILL_W'(strm.valid & strm.ready) - FILL_W'(fifo_take);
    if (result_ready_i) begin
      nxt_st.out_valid = 1'b0;
    end
    if (fifo_take) begin
      nxt_st.out_valid  = 1'b1;
      nxt_st.out_word   = fifo_out[DATA_W-1:0];
      nxt_st.out_second = fifo_out[DATA_W];
    end
    // completion latched once; set wins over clear.
    if (busy_fall && st_ff.state == DAHG_CONV) begin
      nxt_st.done_pend = 1'b1;
      nxt_st.done_ev   = 1'b1;
    end
    if (st_ff.cnt != CNT_RESET) begin
      nxt_st.cnt = st_ff.cnt - 1'b1;
    end
    case (st_ff.state)
      DAHG_IDLE: begin
        nxt_st.start_rdy = ~start_req;
        if (start_ev) begin
          nxt_st.state     = DAHG_START;
          nxt_st.sel       = conv_sel_i;
          nxt_st.start_rdy = 1'b0;
          nxt_st.done_pend = 1'b0;
        end
      end
      DAHG_START: begin
        if (start_n) begin
          nxt_st.state = DAHG_CONV;
          nxt_st.cnt   = CNT_W'(FIXED_DELAY_CYC);
        end
      end
      DAHG_CONV: begin
        // results valid once busy is low.
        if ((!use_fixed_delay_i && (st_ff.done_pend || busy_fall)) ||
            (use_fixed_delay_i && st_ff.cnt == CNT_RESET)) begin
          // Waiting for buffer room keeps the pair from being split.
          if (strm.ready && st_ff.fill <= FILL_LIMIT) begin
            nxt_st.state  = DAHG_RD_LOW;
            nxt_st.rd_cnt = 2'h0;
            // only the selected converter is enabled.
            nxt_st.cs_n   = ~(NUM_CONV'(1) << st_ff.sel);
            // read strobe from strobe and direction.
            // same strobe shape for address-strobe hosts.
            // one read line drives every converter.
            nxt_st.read_n = 1'b0;
            nxt_st.ack_n  = 1'b0;
            nxt_st.cnt    = CNT_W'(READ_LOW_CYC);
          end
        end
      end
      DAHG_RD_LOW: begin
        if (st_ff.cnt == CNT_RESET) begin
          // single wait state before cycle complete.
          nxt_st.state = DAHG_RD_WT;
          nxt_st.cnt   = CNT_W'(WAIT_CYC);
        end
      end
      DAHG_RD_WT: begin
        if (st_ff.cnt == CNT_RESET) begin
          nxt_st.state   = DAHG_RD_END;
          nxt_st.word    = conv_data_i;
          nxt_st.second  = st_ff.rd_cnt[0];
          nxt_st.push    = 1'b1;
          nxt_st.cyc_cpl = 1'b1;
          nxt_st.read_n  = 1'b1;
          nxt_st.ack_n   = 1'b1;
          nxt_st.rd_cnt  = st_ff.rd_cnt + 2'h1;
        end
      end
      DAHG_RD_END: begin
        nxt_st.cyc_cpl = 1'b0;
        // second read to the same select.
        if (st_ff.rd_cnt != RESULTS_PER_CONV) begin
          nxt_st.state  = DAHG_RD_LOW;
          nxt_st.read_n = 1'b0;
          nxt_st.ack_n  = 1'b0;
          nxt_st.cnt    = CNT_W'(READ_LOW_CYC);
        end else begin
          if (!busy_fall) begin
            nxt_st.done_pend = 1'b0;
          end
          nxt_st.cs_n  = '1;
          nxt_st.state = DAHG_SETTLE;
          // settle gap before the next start.
          nxt_st.cnt   = CNT_W'(SETTLE_CYC);
        end
      end
      DAHG_SETTLE: begin
        if (st_ff.cnt == CNT_RESET) begin
          nxt_st.state = DAHG_IDLE;
        end
      end
      default: begin
        nxt_st.state = DAHG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      st_ff <= '{state:      DAHG_IDLE,
                 busy_q:     '0,
                 done_pend:  1'b0,
                 rd_cnt:     2'h0,
                 cnt:        CNT_RESET,
                 read_n:     1'b1,
                 cs_n:       '1,
                 ack_n:      1'b1,
                 cyc_cpl:    1'b0,
                 done_ev:    1'b0,
                 push:       1'b0,
                 word:       '0,
                 second:     1'b0,
                 sel:        '0,
                 start_rdy:  1'b0,
                 fill:       '0,
                 out_valid:  1'b0,
                 out_word:   '0,
                 out_second: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign conversion_start_n_o  = start_n;
  assign read_n_o              = st_ff.read_n;
  assign chip_sel_n_o          = st_ff.cs_n;
  assign host_transfer_ack_n_o = st_ff.ack_n;
  assign host_cycle_complete_o = st_ff.cyc_cpl;
  assign done_event_o          = st_ff.done_ev;
  assign start_ready_o         = st_ff.start_rdy;
  assign result_valid_o        = st_ff.out_valid;
  assign result_data_o         = st_ff.out_word;
  assign result_second_o       = st_ff.out_second;
endmodule
`default_nettype wire

// ==== common/dahg_pkg.sv ====
// Package with constants and types for the dual converter host glue.
package dahg_pkg;
  localparam int unsigned CLK_PERIOD_NS    = 100;
  localparam int unsigned DATA_W           = 14;
  localparam int unsigned FIFO_DEPTH       = 32;
  localparam int unsigned NUM_CONV         = 2;
  localparam int unsigned SEL_W            = 1;
  localparam int unsigned SETTLE_NS        = 400;
  localparam int unsigned SETTLE_CYC       = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned START_LOW_NS     = 200;
  localparam int unsigned START_LOW_CYC    = (START_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned READ_LOW_CYC     = 1;
  localparam int unsigned WAIT_CYC         = 1;
  localparam int unsigned FIXED_DELAY_NS   = 10000;
  localparam int unsigned FIXED_DELAY_CYC  = FIXED_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W            = 8;
  localparam logic [1:0]  RESULTS_PER_CONV = 2'h2;
  localparam logic [CNT_W-1:0] CNT_RESET   = 8'h00;

  typedef enum logic [2:0] {
    DAHG_IDLE   = 3'b000,
    DAHG_START  = 3'b001,
    DAHG_CONV   = 3'b011,
    DAHG_RD_LOW = 3'b010,
    DAHG_RD_WT  = 3'b110,
    DAHG_RD_END = 3'b111,
    DAHG_SETTLE = 3'b101
  } dahg_state_e;
endpackage

// ==== common/dahg_stream_if.sv ====
// Interface carrying result words between glue and buffer.
`timescale 1ns/1ps
`default_nettype none
interface dahg_stream_if;
  import dahg_pkg::*;
  logic              valid;
  logic              ready;
  logic [DATA_W-1:0] data;
  logic              tag;
  modport src (output valid, output data, output tag, input ready);
  modport snk (input valid, input data, input tag, output ready);
endinterface
`default_nettype wire

// ==== rtl/dahg_fifo.sv ====
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module dahg_fifo #(
  parameter int unsigned WIDTH = 15,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clock_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } dahg_fifo_s;
  dahg_fifo_s       st_ff;
  dahg_fifo_s       nxt_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready_o  = (st_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (st_ff.cnt != '0);
  assign out_data_o  = mem[st_ff.rd];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.wr = st_ff.wr + 1'b1;
    end
    if (pop) begin
      nxt_st.rd = st_ff.rd + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Storage has no reset so it maps onto plain RAM.
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[st_ff.wr] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/dahg_start_gen.sv ====
// Conversion start generator: address decoded write or external timer.
`timescale 1ns/1ps
`default_nettype none
module dahg_start_gen (
  input  wire logic clock_i,
  input  wire logic reset_i,
  input  wire logic ext_timer_mode_i,
  input  wire logic ext_start_n_i,
  input  wire logic host_write_i,
  input  wire logic start_addr_hit_i,
  input  wire logic hold_off_i,
  output logic      start_n_o,
  output logic      start_event_o
);
  import dahg_pkg::*;
  typedef struct packed {
    logic             start_n;
    logic             ev;
    logic [CNT_W-1:0] cnt;
  } dahg_start_s;
  dahg_start_s st_ff;
  dahg_start_s nxt_st;
  logic        req;

  // decoded write starts. gated by write strobe.
  assign req = ext_timer_mode_i ? ~ext_start_n_i : (host_write_i & start_addr_hit_i);

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.ev = 1'b0;
    if (st_ff.cnt != CNT_RESET) begin
      nxt_st.cnt = st_ff.cnt - 1'b1;
      if (st_ff.cnt == 8'h01) begin
        nxt_st.start_n = 1'b1;
      end
    end else if (req && !hold_off_i && st_ff.start_n) begin
      nxt_st.start_n = 1'b0;
      nxt_st.ev      = 1'b1;
      nxt_st.cnt     = CNT_W'(START_LOW_CYC);
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      st_ff <= '{start_n: 1'b1, ev: 1'b0, cnt: CNT_RESET};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign start_n_o     = st_ff.start_n;
  assign start_event_o = st_ff.ev;
endmodule
`default_nettype wire

// ==== test/dahg_glue_monitor.sv ====
// Checker of the glue's start, select and read pin timing.
`timescale 1ns/1ps
`default_nettype none
module dahg_glue_monitor (
  input wire logic       clock_i,
  input wire logic       reset_i,
  input wire logic [1:0] busy_i,
  input wire logic       conversion_start_n_o,
  input wire logic       read_n_o,
  input wire logic [1:0] chip_sel_n_o,
  input wire logic       host_transfer_ack_n_o,
  input wire logic       host_cycle_complete_o,
  input wire logic       done_event_o,
  input wire logic       start_ready_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  a_start_two_low:
    assert property ($fell(conversion_start_n_o) |=> !conversion_start_n_o ##1 conversion_start_n_o)
    else $error("start pulse width wrong");
  a_ack_tracks_read:
    assert property (host_transfer_ack_n_o == read_n_o) else $error("acknowledge differs from read window");
  a_read_one_select:
    assert property (!read_n_o |-> $onehot(~chip_sel_n_o)) else $error("read without a single select");
  a_read_wait_width:
    assert property ($fell(read_n_o) |-> !read_n_o [*4] ##1 read_n_o) else $error("read strobe width wrong");
  a_complete_at_end:
    assert property (host_cycle_complete_o == $rose(read_n_o)) else $error("cycle complete misplaced");
  a_no_read_busy:
    assert property (!read_n_o |-> (busy_i & ~chip_sel_n_o) == 2'h0) else $error("read during conversion");
  a_settle_gap:
    assert property ($rose(read_n_o) |-> conversion_start_n_o [*4]) else $error("start too soon after read");
  a_done_then_read:
    assert property (done_event_o |-> ##[0:1000] $fell(read_n_o)) else $error("no read after completion");
  a_done_single:
    assert property (done_event_o |=> !done_event_o) else $error("completion event repeated");
  a_ready_idle:
    assert property (start_ready_o |-> conversion_start_n_o && read_n_o && chip_sel_n_o == 2'h3)
    else $error("ready while bus busy");
endmodule
bind dahg_host_glue dahg_glue_monitor u_dahg_glue_monitor (.clock_i, .reset_i, .busy_i, .conversion_start_n_o,
  .read_n_o, .chip_sel_n_o, .host_transfer_ack_n_o, .host_cycle_complete_o, .done_event_o, .start_ready_o);
`default_nettype wire

// ==== test/dahg_conv_model.sv ====
// Behavioural model of two converters behind the glue's pins.
`timescale 1ns/1ps
`default_nettype none
module dahg_conv_model #(
  parameter int unsigned CONV_CYC = 20
) (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        start_n_i,
  input  wire logic        read_n_i,
  input  wire logic [1:0]  cs_n_i,
  input  wire logic [13:0] word_a_i,
  input  wire logic [13:0] word_b_i,
  output logic      [1:0]  busy_o,
  output logic      [13:0] data_o
);
  logic        start_q;
  logic        read_q;
  logic [1:0]  second_q;
  logic [13:0] last_q;
  logic [13:0] word;
  logic        drive;
  int          left [2];
  assign drive = !read_n_i && (cs_n_i != 2'h3);
  // Converter 1 answers inverted words so a wrong select shows in the data.
  assign word = (second_q[cs_n_i[0]] ? word_b_i : word_a_i) ^ {14{!cs_n_i[1]}};
  // A released bus shows the inverse of the last word, never a stale copy.
  assign data_o = drive ? word : ~last_q;
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      start_q  <= 1'h1;
      read_q   <= 1'h1;
      second_q <= 2'h0;
      busy_o   <= 2'h0;
      last_q   <= 14'h0000;
      left     <= '{0, 0};
    end else begin
      start_q <= start_n_i;
      read_q  <= read_n_i;
      if (drive) last_q <= word;
      for (int k = 0; k < 2; k++) begin
        // busy marks completion; converter 1 is the slow one.
        if (start_q && !start_n_i) begin
          left[k]     <= CONV_CYC + 7 * k;
          busy_o[k]   <= 1'h1;
          second_q[k] <= 1'h0;
        end else if (left[k] > 0) begin
          left[k]   <= left[k] - 1;
          busy_o[k] <= left[k] > 1;
        end
        if (!read_q && read_n_i && !cs_n_i[k]) second_q[k] <= 1'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/dahg_host_glue_bench.sv ====
// Self-checking bench: conversions, result pairs, refusals and a full buffer.
`timescale 1ns/1ps
`default_nettype none
module dahg_host_glue_bench;
  import dahg_pkg::*;
  typedef struct packed {logic ext; logic sel; logic fx; logic [13:0] a; logic [13:0] b;} dahg_row_s;
  localparam dahg_row_s ROWS [4] = '{'{1'h0, 1'h0, 1'h0, 14'h0ABC, 14'h1234}, '{1'h0, 1'h1, 1'h0, 14'h3FFF, 14'h0000},
    '{1'h1, 1'h0, 1'h0, 14'h2AAA, 14'h1555}, '{1'h1, 1'h1, 1'h1, 14'h0001, 14'h2000}};
  logic        clock_i, reset_i, ext_timer_mode_i, ext_start_n_i, host_write_i, start_addr_hit_i;
  logic        use_fixed_delay_i, result_ready_i, conversion_start_n_o, read_n_o, host_transfer_ack_n_o;
  logic        host_cycle_complete_o, done_event_o, result_valid_o, result_second_o, start_ready_o;
  logic [0:0]  conv_sel_i;
  logic [1:0]  busy_i, chip_sel_n_o;
  logic [13:0] conv_data_i, result_data_o, wa, wb;
  int          miscompares = 0, check_count = 0, starts = 0, n, m;
  dahg_host_glue u_dahg_host_glue (.clock_i, .reset_i, .ext_timer_mode_i, .ext_start_n_i, .host_write_i,
    .start_addr_hit_i, .use_fixed_delay_i, .conv_sel_i, .busy_i, .conv_data_i, .conversion_start_n_o, .read_n_o,
    .chip_sel_n_o, .host_transfer_ack_n_o, .host_cycle_complete_o, .done_event_o, .result_valid_o,
    .result_ready_i, .result_data_o, .result_second_o, .start_ready_o);
  dahg_conv_model #(.CONV_CYC(20)) u_dahg_conv_model (.clock_i(clock_i), .reset_i(reset_i),
    .start_n_i(conversion_start_n_o), .read_n_i(read_n_o), .cs_n_i(chip_sel_n_o), .word_a_i(wa),
    .word_b_i(wb), .busy_o(busy_i), .data_o(conv_data_i));
  always #(CLK_PERIOD_NS / 2) clock_i = ~clock_i;
  always @(negedge conversion_start_n_o) if (!reset_i) starts++;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic pop(input logic [13:0] d, input logic s);
    n = 0;
    @(negedge clock_i);
    while (result_valid_o !== 1'h1 && n < 500) begin @(negedge clock_i); n++; end
    check(result_valid_o, 1'h1, "result valid");
    check(result_data_o, d, "result data");
    check(result_second_o, s, "result order");
    @(posedge clock_i);
  endtask
  // The request is held until the start strobe is seen low, then released.
  task automatic go(input dahg_row_s r);
    n = 0;
    @(negedge clock_i);
    while (start_ready_o !== 1'h1 && n < 300) begin @(negedge clock_i); n++; end
    @(posedge clock_i);
    ext_timer_mode_i <= r.ext;
    conv_sel_i <= r.sel;
    use_fixed_delay_i <= r.fx;
    wa <= r.a;
    wb <= r.b;
    ext_start_n_i <= !r.ext;
    host_write_i <= !r.ext;
    start_addr_hit_i <= !r.ext;
    @(negedge clock_i);
    while (conversion_start_n_o !== 1'h0 && n < 600) begin @(negedge clock_i); n++; end
    check(conversion_start_n_o, 1'h0, "start taken");
    @(posedge clock_i);
    ext_start_n_i <= 1'h1;
    host_write_i <= 1'h0;
    start_addr_hit_i <= 1'h0;
  endtask
  task automatic reads(input dahg_row_s r);
    n = 0;
    @(negedge clock_i);
    while (conversion_start_n_o !== 1'h1) @(negedge clock_i);
    while (read_n_o !== 1'h0 && n < 2000) begin @(negedge clock_i); n++; end
    check(read_n_o, 1'h0, "read started");
    check(n >= FIXED_DELAY_CYC - 1, r.fx, "fixed delay wait");
    check(chip_sel_n_o, r.sel ? 2'h1 : 2'h2, "select");
    pop(r.a ^ {14{r.sel}}, 1'h0);
    pop(r.b ^ {14{r.sel}}, 1'h1);
  endtask
  initial begin
    #(CLK_PERIOD_NS * 20000);
    miscompares++;
    close_out();
  end
  initial begin
    clock_i = 1'h0;
    reset_i = 1'h1;
    {ext_timer_mode_i, host_write_i, start_addr_hit_i, use_fixed_delay_i, conv_sel_i} = 5'h00;
    {ext_start_n_i, result_ready_i, wa, wb} = {2'h3, 28'h0000000};
    repeat (10) @(posedge clock_i);
    @(negedge clock_i);
    check({conversion_start_n_o, read_n_o, chip_sel_n_o, host_transfer_ack_n_o, result_valid_o,
      start_ready_o}, 7'h7C, "reset outputs");
    @(posedge clock_i);
    reset_i <= 1'h0;
    foreach (ROWS[i]) begin go(ROWS[i]); reads(ROWS[i]); end
    m = starts;
    @(posedge clock_i);
    ext_timer_mode_i <= 1'h0;
    host_write_i <= 1'h1;
    repeat (5) @(posedge clock_i);
    host_write_i <= 1'h0;
    start_addr_hit_i <= 1'h1;
    repeat (5) @(posedge clock_i);
    start_addr_hit_i <= 1'h0;
    repeat (3) @(negedge clock_i);
    check(starts - m, 0, "ungated start");
    go(ROWS[0]);
    @(posedge clock_i);
    host_write_i <= 1'h1;
    start_addr_hit_i <= 1'h1;
    repeat (10) @(posedge clock_i);
    host_write_i <= 1'h0;
    start_addr_hit_i <= 1'h0;
    reads(ROWS[0]);
    check(starts - m, 1, "start while busy");
    result_ready_i <= 1'h0;
    repeat (17) go(ROWS[2]);
    repeat (60) @(negedge clock_i);
    check(read_n_o, 1'h1, "read with full buffer");
    @(posedge clock_i);
    result_ready_i <= 1'h1;
    repeat (17) begin pop(ROWS[2].a, 1'h0); pop(ROWS[2].b, 1'h1); end
    close_out();
  end
endmodule
`default_nettype wire
